// File: perm_defines.svh
// constants for the permission and request status block
`ifndef PERM_DEFINES_SVH
`define PERM_DEFINES_SVH
// security group bits
`define SEC_KEY_PRI_BIT 0
`define SEC_KEY_ALT_BIT 1
`define SEC_WRAP_KEY_BIT 2
`define SEC_SECONDARY_MASK_BIT 4
`define SEC_OWNER_PIN_BIT 6
`define SEC_SECONDARY_PIN_BIT 7
// green-power group bits
`define GP_TX_BIT 0
`define GP_SEC_BIT 1
`define GP_BTN_BIT 2
`define GP_PROTO_BIT 4
`define GP_LEAVE_BIT 5
// system group bits
`define SYS_COMMISSION_BIT 0
`define SYS_FACTORY_BIT 1
`define SYS_BUTTON_BIT 4
`define SYS_RADIO_BIT 5
// writable (non-reserved) bits per group
`define SEC_VALID_MASK 8'hD7
`define GP_VALID_MASK 8'h37
`define LE_VALID_MASK 8'h3F
`define SYS_VALID_MASK 8'h33
// reset values of the masks
`define OWNER_SEC_RESET 8'hD7
`define SECONDARY_SEC_RESET 8'h87
`define GP_RESET 8'h37
`define LE_RESET 8'h3F
`define SYS_RESET 8'h33
// outcome codes (upper nibble)
`define OUT_SUCCESS 4'h3
`define OUT_BUSY 4'h5
`define OUT_PIN_ERR 4'h7
`define OUT_PERM_ERR 4'h9
`define OUT_PARAM_ERR 4'hB
// requester offset in lower nibble
`define SECONDARY_REQ_OFS 4'h8
`define OUTCOME_RESET 8'h00
`endif

// File: perm_pkg.sv
// types for the permission and request status block
`default_nettype none
package perm_pkg;
   typedef enum logic [1:0] {
      REQ_CONFIG = 2'h0,
      REQ_COMMISSION = 2'h1,
      REQ_FACTORY = 2'h2,
      REQ_LEAVE = 2'h3
   } req_kind_e;
   typedef enum logic [3:0] {
      ST_IDLE = 4'h1,
      ST_CHECK = 4'h2,
      ST_APPLY = 4'h4,
      ST_DONE = 4'h8
   } eval_state_e;
endpackage
`default_nettype wire

// File: perm_check.sv
// combinational grant check of one request against one user's masks
`include "perm_defines.svh"
`default_nettype none
module perm_check
   import perm_pkg::*;
(
   input wire logic [7:0] sec_mask,
   input wire logic [7:0] gp_mask,
   input wire logic [7:0] le_mask,
   input wire logic [7:0] sys_mask,
   input wire logic [31:0] touched,
   input wire logic [1:0] kind,
   output logic granted
);
   logic [31:0] eff;
   logic [31:0] need;
   always_comb begin
      // reserved bits never granted
      eff = {sys_mask & `SYS_VALID_MASK, le_mask & `LE_VALID_MASK,
         gp_mask & `GP_VALID_MASK, sec_mask & `SEC_VALID_MASK};
      need = touched;
      unique case (req_kind_e'(kind))
         REQ_COMMISSION: need = 32'h0000_0000 | (32'h1 << (24 + `SYS_COMMISSION_BIT));
         REQ_FACTORY: need = 32'h0000_0000 | (32'h1 << (24 + `SYS_FACTORY_BIT));
         REQ_LEAVE: need = 32'h0000_0000 | (32'h1 << (8 + `GP_LEAVE_BIT));
         REQ_CONFIG: need = touched;
      endcase
      granted = ((need & ~eff) == 32'h0000_0000);
   end
endmodule
`default_nettype wire

// File: seq_select.sv
// active sequence counter selection and storage
`default_nettype none
module seq_select (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic le_step,
   input wire logic gp_step,
   input wire logic use_gp,
   output logic [31:0] active_count
);
   logic [31:0] le_cnt_q, le_cnt_d, gp_cnt_q, gp_cnt_d;
   always_comb begin
      le_cnt_d = le_cnt_q + {31'h0, le_step};
      gp_cnt_d = gp_cnt_q + {31'h0, gp_step};
   end
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         le_cnt_q <= 32'h0;
         gp_cnt_q <= 32'h0;
      end else begin
         le_cnt_q <= le_cnt_d;
         gp_cnt_q <= gp_cnt_d;
      end
   end
   assign active_count = use_gp ? gp_cnt_q : le_cnt_q;
endmodule
`default_nettype wire

// File: config_permission_status.sv
// permission masks, request evaluation and status byte
//
// Behaviour
// - security byte: keys bits 0-2, secondary mask 4, owner PIN 6, secondary PIN 7
// - only owner may change secondary mask; owner PIN owner-only by default
// - both users may change the secondary PIN
// - reserved bits never granted; touching one means not permitted
// - non-reserved green-power, low-energy, system items default to both users
// - green-power byte: tx 0, security 1, buttons 2, protocol 4, leave 5
// - low-energy byte bits 0-5: tx, sec, buttons, address, maker, channel
// - system byte: commission 0, factory 1, buttons 4, radio 5
// - two separate 32-bit counters, low-energy and green-power
// - counter register returns the counter of the selected radio
// - status byte shows only the latest request's outcome
// - upper nibble: 3 ok, 5 busy, 7 PIN, 9 permission, B parameter
// - lower nibble 1-4 owner requests, 9-C secondary requests
// - wrong PIN for requester gives PIN error
// - missing permission gives permission error
`include "perm_defines.svh"
`default_nettype none
module config_permission_status
   import perm_pkg::*;
#(
   parameter int PIN_W = 32
) (
   input wire logic sys_clk,
   input wire logic nrst,
   input wire logic req_valid,
   input wire logic req_secondary,
   input wire logic [1:0] req_kind,
   input wire logic [PIN_W-1:0] req_pin,
   input wire logic [31:0] req_items,
   input wire logic [31:0] req_values,
   input wire logic req_param_bad,
   input wire logic apply_done,
   input wire logic le_step,
   input wire logic gp_step,
   input wire logic use_gp,
   output logic [7:0] owner_sec_mask,
   output logic [7:0] secondary_sec_mask,
   output logic [7:0] green_power_option_mask,
   output logic [7:0] low_energy_option_mask,
   output logic [7:0] system_option_mask,
   output logic [31:0] active_sequence_counter,
   output logic [7:0] request_outcome,
   output logic busy
);
   // owner's non-security masks: fixed full grant, secondary ones are programmable
   logic [PIN_W-1:0] owner_pin_q, owner_pin_d, secondary_pin_q, secondary_pin_d;
   logic [7:0] sec_q, sec_d, gp_q, gp_d, le_q, le_d, sys_q, sys_d;
   logic [7:0] outcome_q, outcome_d;
   eval_state_e state_q, state_d;
   logic secondary_q, secondary_d;
   logic [1:0] kind_q, kind_d;
   logic [PIN_W-1:0] pin_q, pin_d;
   logic [31:0] items_q, items_d, values_q, values_d;
   logic bad_q, bad_d;
   logic owner_ok, second_ok, granted;
   logic [31:0] seq_now;
   logic [3:0] code_lo;

   perm_check owner_chk (
      .sec_mask(`OWNER_SEC_RESET),
      .gp_mask(`GP_VALID_MASK),
      .le_mask(`LE_VALID_MASK),
      .sys_mask(`SYS_VALID_MASK),
      .touched(items_q),
      .kind(kind_q),
      .granted(owner_ok)
   );
   perm_check second_chk (
      // secondary mask item is never granted to the secondary user
      .sec_mask(sec_q & ~(8'h01 << `SEC_SECONDARY_MASK_BIT)),
      .gp_mask(gp_q),
      .le_mask(le_q),
      .sys_mask(sys_q),
      .touched(items_q),
      .kind(kind_q),
      .granted(second_ok)
   );
   seq_select seq (
      .sys_clk(sys_clk),
      .nrst(nrst),
      .le_step(le_step),
      .gp_step(gp_step),
      .use_gp(use_gp),
      .active_count(seq_now)
   );

   assign granted = secondary_q ? second_ok : owner_ok;
   assign code_lo = {2'h0, kind_q} + 4'h1 + (secondary_q ? `SECONDARY_REQ_OFS : 4'h0);

   always_comb begin
      state_d = state_q;
      outcome_d = outcome_q;
      secondary_d = secondary_q;
      kind_d = kind_q;
      pin_d = pin_q;
      items_d = items_q;
      values_d = values_q;
      bad_d = bad_q;
      sec_d = sec_q;
      gp_d = gp_q;
      le_d = le_q;
      sys_d = sys_q;
      owner_pin_d = owner_pin_q;
      secondary_pin_d = secondary_pin_q;
      unique case (state_q)
         ST_IDLE: begin
            if (req_valid) begin
               secondary_d = req_secondary;
               kind_d = req_kind;
               pin_d = req_pin;
               items_d = req_items;
               values_d = req_values;
               bad_d = req_param_bad;
               state_d = ST_CHECK;
            end
         end
         ST_CHECK: begin
            // whole byte written at once, previous outcome discarded
            if (pin_q != (secondary_q ? secondary_pin_q : owner_pin_q)) begin
               outcome_d = {`OUT_PIN_ERR, code_lo};
               state_d = ST_IDLE;
            end else if (!granted) begin
               outcome_d = {`OUT_PERM_ERR, code_lo};
               state_d = ST_IDLE;
            end else if (bad_q) begin
               outcome_d = {`OUT_PARAM_ERR, code_lo};
               state_d = ST_IDLE;
            end else begin
               outcome_d = {`OUT_BUSY, code_lo};
               state_d = ST_APPLY;
            end
         end
         ST_APPLY: begin
            if (apply_done) begin
               state_d = ST_DONE;
            end
         end
         ST_DONE: begin
            if (req_kind_e'(kind_q) == REQ_CONFIG) begin
               // secondary mask carried in values[31:0]; stored minus reserved bits
               if (items_q[`SEC_SECONDARY_MASK_BIT]) begin
                  sec_d = values_q[7:0] & `SEC_VALID_MASK;
                  gp_d = values_q[15:8] & `GP_VALID_MASK;
                  le_d = values_q[23:16] & `LE_VALID_MASK;
                  sys_d = values_q[31:24] & `SYS_VALID_MASK;
               end
               if (items_q[`SEC_OWNER_PIN_BIT]) begin
                  owner_pin_d = values_q[PIN_W-1:0];
               end
               if (items_q[`SEC_SECONDARY_PIN_BIT]) begin
                  secondary_pin_d = values_q[PIN_W-1:0];
               end
            end
            outcome_d = {`OUT_SUCCESS, code_lo};
            state_d = ST_IDLE;
         end
         default: begin
            state_d = ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         state_q <= ST_IDLE;
         outcome_q <= `OUTCOME_RESET;
         secondary_q <= 1'b0;
         kind_q <= 2'h0;
         pin_q <= '0;
         items_q <= 32'h0;
         values_q <= 32'h0;
         bad_q <= 1'b0;
         sec_q <= `SECONDARY_SEC_RESET;
         gp_q <= `GP_RESET;
         le_q <= `LE_RESET;
         sys_q <= `SYS_RESET;
         owner_pin_q <= '0;
         secondary_pin_q <= '0;
      end else begin
         state_q <= state_d;
         outcome_q <= outcome_d;
         secondary_q <= secondary_d;
         kind_q <= kind_d;
         pin_q <= pin_d;
         items_q <= items_d;
         values_q <= values_d;
         bad_q <= bad_d;
         sec_q <= sec_d;
         gp_q <= gp_d;
         le_q <= le_d;
         sys_q <= sys_d;
         owner_pin_q <= owner_pin_d;
         secondary_pin_q <= secondary_pin_d;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         owner_sec_mask <= 8'h00;
         secondary_sec_mask <= 8'h00;
         green_power_option_mask <= 8'h00;
         low_energy_option_mask <= 8'h00;
         system_option_mask <= 8'h00;
         active_sequence_counter <= 32'h0;
         request_outcome <= 8'h00;
         busy <= 1'b0;
      end else begin
         owner_sec_mask <= `OWNER_SEC_RESET;
         secondary_sec_mask <= sec_q;
         green_power_option_mask <= gp_q;
         low_energy_option_mask <= le_q;
         system_option_mask <= sys_q;
         active_sequence_counter <= seq_now;
         request_outcome <= outcome_q;
         busy <= (state_q != ST_IDLE);
      end
   end

   a_outcome_holds: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_IDLE && !req_valid) |=> $stable(outcome_q))
      else $error("status byte changed without evaluation");
   a_pin_error_code: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_CHECK && pin_q != (secondary_q ? secondary_pin_q : owner_pin_q))
      |=> outcome_q[7:4] == 4'h7)
      else $error("pin mismatch not reported");
   a_perm_error_code: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_CHECK && pin_q == (secondary_q ? secondary_pin_q : owner_pin_q)
      && !granted) |=> outcome_q[7:4] == 4'h9)
      else $error("permission failure not reported");
   a_second_no_mask: assert property (@(posedge sys_clk) disable iff (!nrst)
      (secondary_q && kind_q == 2'h0 && items_q[4]) |-> !second_ok)
      else $error("secondary user granted own mask");
   a_reserved_denied: assert property (@(posedge sys_clk) disable iff (!nrst)
      (kind_q == 2'h0 && (items_q & 32'hCCC0_C828) != 32'h0) |-> !granted)
      else $error("reserved item granted");
   a_reserved_clear: assert property (@(posedge sys_clk) disable iff (!nrst)
      ((sec_q & 8'h28) == 8'h00 && (gp_q & 8'hC8) == 8'h00))
      else $error("reserved mask bit stored");
   a_success_after: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_APPLY && apply_done) |=> ##1 outcome_q[7:4] == 4'h3)
      else $error("success not reported");
   a_code_low: assert property (@(posedge sys_clk) disable iff (!nrst)
      (state_q == ST_CHECK) |=> outcome_q[3:0] == {secondary_q, 1'b0, kind_q} + 4'h1)
      else $error("wrong requester code");
   a_counter_sel: assert property (@(posedge sys_clk) disable iff (!nrst)
      $stable(use_gp) && !le_step && !gp_step ##1 1'b1 |=>
      active_sequence_counter == $past(seq_now))
      else $error("counter register not following");
endmodule
`default_nettype wire

// File: nfc_reader_model.sv
// behavioural nfc reader that issues one request at a time
`default_nettype none
module nfc_reader_model (
   input wire logic sys_clk,
   output logic req_valid,
   output logic req_secondary,
   output logic [1:0] req_kind,
   output logic [31:0] req_pin,
   output logic [31:0] req_items,
   output logic [31:0] req_values,
   output logic req_param_bad
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      req_valid = 1'b0;
      req_secondary = 1'b0;
      req_kind = 2'h0;
      req_pin = 32'h0;
      req_items = 32'h0;
      req_values = 32'h0;
      req_param_bad = 1'b0;
   end
   // one-cycle request; released pin, items, values and bad flag show inverted junk, secondary and kind hold
   task issue(input logic s, input logic [1:0] k, input logic [31:0] p, input logic [31:0] i,
              input logic [31:0] v, input logic b);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_secondary <= s;
      req_kind <= k;
      req_pin <= p;
      req_items <= i;
      req_values <= v;
      req_param_bad <= b;
      @(posedge sys_clk);
      req_valid <= 1'b0;
      req_pin <= ~p;
      req_items <= ~i;
      req_values <= ~v;
      req_param_bad <= ~b;
   endtask
endmodule
`default_nettype wire

// File: config_permission_status_bench.sv
// self-checking bench for the permission and status block
`default_nettype none
module config_permission_status_bench;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk = 1'b0;
   logic nrst = 1'b0;
   logic apply_done = 1'b0;
   logic le_step = 1'b0;
   logic gp_step = 1'b0;
   logic use_gp = 1'b0;
   logic req_valid, req_secondary, req_param_bad, busy;
   logic [1:0] req_kind;
   logic [31:0] req_pin, req_items, req_values, active_sequence_counter;
   logic [7:0] owner_sec_mask, secondary_sec_mask, green_power_option_mask;
   logic [7:0] low_energy_option_mask, system_option_mask, request_outcome;
   int fail_count = 0;
   int samples_checked = 0;
   always #2 sys_clk = ~sys_clk;
   nfc_reader_model reader (.sys_clk(sys_clk), .req_valid(req_valid),
      .req_secondary(req_secondary), .req_kind(req_kind), .req_pin(req_pin),
      .req_items(req_items), .req_values(req_values), .req_param_bad(req_param_bad));
   config_permission_status #(.PIN_W(32)) DUT (.sys_clk(sys_clk), .nrst(nrst),
      .req_valid(req_valid), .req_secondary(req_secondary), .req_kind(req_kind),
      .req_pin(req_pin), .req_items(req_items), .req_values(req_values),
      .req_param_bad(req_param_bad), .apply_done(apply_done), .le_step(le_step),
      .gp_step(gp_step), .use_gp(use_gp), .owner_sec_mask(owner_sec_mask),
      .secondary_sec_mask(secondary_sec_mask),
      .green_power_option_mask(green_power_option_mask),
      .low_energy_option_mask(low_energy_option_mask),
      .system_option_mask(system_option_mask),
      .active_sequence_counter(active_sequence_counter),
      .request_outcome(request_outcome), .busy(busy));
   task stop_test();
      $display("checks %0d mismatches %0d", samples_checked, fail_count);
      if (fail_count == 0 && samples_checked > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask
   task check(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("mismatch %0t seen %h expected %h", $time, seen, exp);
      end
   endtask
   task settle(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask
   task wait_idle();
      int n;
      n = 0;
      while (busy !== 1'b0 && n < 50) begin
         @(posedge sys_clk);
         n++;
      end
      if (n >= 50) begin
         fail_count++;
         $display("mismatch %0t busy never dropped", $time);
         stop_test();
      end
   endtask
   task finish_apply(input logic [7:0] done_code);
      @(posedge sys_clk);
      apply_done <= 1'b1;
      @(posedge sys_clk);
      apply_done <= 1'b0;
      settle(3);
      check(request_outcome, done_code);
   endtask
   // one request; a busy code is completed with apply_done
   task run(input logic s, input logic [1:0] k, input logic [31:0] p, input logic [31:0] i,
            input logic [31:0] v, input logic b, input logic [7:0] code);
      reader.issue(s, k, p, i, v, b);
      settle(4);
      check(request_outcome, code);
      check({31'h0, busy}, {31'h0, code[7:4] == 4'h5});
      if (code[7:4] == 4'h5) begin
         finish_apply({4'h3, code[3:0]});
      end
      wait_idle();
   endtask
   task s_reset_values();
      check(owner_sec_mask, 8'hD7);
      check(secondary_sec_mask, 8'h87);
      check({system_option_mask, low_energy_option_mask, green_power_option_mask},
            24'h333F37);
      check(request_outcome, 8'h00);
      check(active_sequence_counter, 32'h0);
   endtask
   task s_errors();
      run(1'b1, 2'h0, 32'h0, 32'h0000_0010, 32'h0, 1'b0, 8'h99);
      run(1'b1, 2'h0, 32'h0, 32'h0000_0040, 32'h0, 1'b0, 8'h99);
      run(1'b0, 2'h0, 32'h0, 32'h0000_0008, 32'h0, 1'b0, 8'h91);
      run(1'b1, 2'h0, 32'h0, 32'h0400_0000, 32'h0, 1'b0, 8'h99);
      run(1'b0, 2'h0, 32'h0, 32'h0000_0100, 32'h0, 1'b1, 8'hB1);
      run(1'b0, 2'h0, 32'h9, 32'h0000_0100, 32'h0, 1'b0, 8'h71);
   endtask
   task s_pin_change();
      run(1'b0, 2'h0, 32'h0, 32'h0000_0080, 32'h1234, 1'b0, 8'h51);
      run(1'b1, 2'h0, 32'h0, 32'h0000_0100, 32'h0, 1'b0, 8'h79);
      run(1'b1, 2'h0, 32'h1234, 32'h0000_0080, 32'h55, 1'b0, 8'h59);
      run(1'b1, 2'h0, 32'h55, 32'h0020_0000, 32'h0, 1'b0, 8'h59);
   endtask
   task s_kinds();
      for (int k = 1; k < 4; k++) begin
         run(1'b0, k[1:0], 32'h0, 32'h0, 32'h0, 1'b0, 8'h51 + k[7:0]);
         run(1'b1, k[1:0], 32'h55, 32'h0, 32'h0, 1'b0, 8'h59 + k[7:0]);
      end
   endtask
   task s_restrict();
      run(1'b0, 2'h0, 32'h0, 32'h0000_0010, 32'h333F_FE87, 1'b0, 8'h51);
      check(green_power_option_mask, 8'h36);
      check(secondary_sec_mask, 8'h87);
      run(1'b1, 2'h0, 32'h55, 32'h0000_0100, 32'h0, 1'b0, 8'h99);
      run(1'b1, 2'h0, 32'h55, 32'h0000_2000, 32'h0, 1'b0, 8'h59);
   endtask
   task s_refused();
      reader.issue(1'b0, 2'h1, 32'h0, 32'h0, 32'h0, 1'b0);
      reader.issue(1'b0, 2'h0, 32'h7, 32'h0, 32'h0, 1'b0);
      settle(2);
      check(request_outcome, 8'h52);
      finish_apply(8'h32);
      wait_idle();
   endtask
   task s_counters();
      for (int n = 0; n < 5; n++) begin
         @(posedge sys_clk);
         gp_step <= 1'b1;
         le_step <= (n < 3);
      end
      @(posedge sys_clk);
      gp_step <= 1'b0;
      le_step <= 1'b0;
      settle(3);
      check(active_sequence_counter, 32'd3);
      @(posedge sys_clk);
      use_gp <= 1'b1;
      settle(3);
      check(active_sequence_counter, 32'd5);
   endtask
   initial begin
      settle(4);
      @(posedge sys_clk);
      nrst <= 1'b1;
      settle(2);
      s_reset_values();
      s_errors();
      s_pin_change();
      s_kinds();
      s_restrict();
      s_refused();
      s_counters();
      stop_test();
   end
endmodule
`default_nettype wire
